// File: logic/cps_top.v
// Digital supervision of a switch-mode charger: switch gating, safety timer,
// battery detection, fault recovery, open-drain status pins, APB registers.
// Assumes comparator flags are asynchronous and the PWM cycle start is a pin.
`timescale 1ns/1ps
`include "cps_regs.vh"
// Function
// - Sense drop under 5 mV keeps low-side off for the rest of cycle.
// - Averaged sense under 1.25 mV forces non-synchronous operation.
// - In DCM low-side only pulses 80 ns when bootstrap is under 4.2 V.
// - Input overvoltage disables charge and moves system supply to battery.
// - Supply undervoltage lockout holds every function disabled; systemFromBattery still follows input overvoltage and sleep.
// - Battery at or above 105 percent blocks every high-side turn-on.
// - 8 mA discharge sink is on only while charging.
// - Battery overvoltage pauses the safety timer, which later resumes.
// - Charge current above 160 percent turns high-side off until it drops.
// - Die overtemperature stops converter; restart uses soft-start.
// - Die overtemperature pauses the safety timer.
// - Charge only inside thermistor cold/hot limits; else suspend charge and timer.
// - Thermistor in mild cold or warm band cuts current to one eighth.
// - Temperature suspend turns off both converter switches.
// - Timeout above recharge clears when battery drops below, then detection.
// - Power-on reset or enable low clears a latched timer fault.
// - Timeout below recharge applies probe current until battery rises above.
// - Supply-valid pin on when no lockout, no overvoltage, no sleep.
// - Charging needs enable high plus every other condition.
// - Falling edge of enable resets timers and clears latched faults.
// - Undriven enable counts as low; there is no pull-down, so it reads low only while reset is held.
// - Status on charging, off done or sleep, blink on fault conditions.
// - Fast charge entry ramps current limit through eight 1.6 ms steps.
// - Five-hour fast-charge safety timer raises a fault that stops charge.
// - Detection windows of 500 ms or 1 s expiring declare battery present.
module cps_top #(
	parameter [31:0] STEP_CYC      = `CPS_STEP_CYC,
	parameter [31:0] DET_SHORT_CYC = `CPS_DET_SHORT_CYC,
	parameter [31:0] DET_LONG_CYC  = `CPS_DET_LONG_CYC,
	parameter [31:0] BLINK_CYC     = `CPS_BLINK_CYC,
	parameter [31:0] SEC_CYC       = `CPS_SEC_CYC
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        reset_n,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Comparator flags, asynchronous
	input  wire        senseUnder5mv,
	input  wire        senseAvgUnder1p25mv,
	input  wire        bootstrapLow,
	input  wire        inputOvervoltage,
	input  wire        supplyUndervoltageLockout,
	input  wire        cellOvervoltageProtect,
	input  wire        dieOvertempShutdown,
	input  wire        thermistorOutsideLimits,
	input  wire        thermistorMildBand,
	input  wire        overcurrent160,
	input  wire        sleepCondition,
	input  wire        cellAboveRecharge,
	input  wire        cellBelowLowThreshold,
	input  wire        chargeEnable,
	// PWM cycle start and modulator request, same clock
	input  wire        pwmCycleStart,
	input  wire        pwmHighReq,
	// Switch commands and supply path
	output reg         highSideOn,
	output reg         lowSideOn,
	output reg         systemFromBattery,
	output reg         dischargeSinkOn,
	output reg         faultProbeCurrentOn,
	output reg         precharge125mA,
	output reg  [3:0]  currentStep,
	output reg         currentDivBy8,
	// Open-drain pins: output level is always low, enable pulls
	output reg         supplyValidOe,
	output reg         statusOe
);
	localparam ST_OFF    = 6'b000001;
	localparam ST_DETLOW = 6'b000010;
	localparam ST_DETRCH = 6'b000100;
	localparam ST_CHARGE = 6'b001000;
	localparam ST_DONE   = 6'b010000;
	localparam ST_FAULT  = 6'b100000;

	wire sUnder5;
	wire sAvgLow;
	wire sBoot;
	wire sOvIn;
	wire sUvlo;
	wire sCellOv;
	wire sHot;
	wire sTsOut;
	wire sTsMild;
	wire sOc;
	wire sSleep;
	wire sAboveRch;
	wire sBelowLow;
	wire sEnable;
	wire [13:0] asyncVec;
	wire [13:0] syncVec;

	assign asyncVec = {senseUnder5mv, senseAvgUnder1p25mv, bootstrapLow, inputOvervoltage,
		supplyUndervoltageLockout, cellOvervoltageProtect, dieOvertempShutdown,
		thermistorOutsideLimits, thermistorMildBand, overcurrent160, sleepCondition,
		cellAboveRecharge, cellBelowLowThreshold, chargeEnable};
	assign {sUnder5, sAvgLow, sBoot, sOvIn, sUvlo, sCellOv, sHot, sTsOut, sTsMild, sOc,
		sSleep, sAboveRch, sBelowLow, sEnable} = syncVec;

	genvar gi;
	generate
		for (gi = 0; gi < 14; gi = gi + 1) begin : g_sync
			cps_sync2 u_sync (
				.core_clk (core_clk),
				.reset_n  (reset_n),
				.asyncIn  (asyncVec[gi]),
				.syncOut  (syncVec[gi])
			);
		end
	endgenerate

	// Reset value of the sync stage is low, so enable reads as off while reset is held
	reg        enPrev_ff;
	reg [5:0]  state_ff;
	reg [5:0]  nxt_state;
	reg        ctrlFast_ff;
	reg        underLatch_ff;
	reg [3:0]  refresh_ff;
	reg [31:0] secCnt_ff;
	reg [14:0] safetySec_ff;
	reg [31:0] stepCnt_ff;
	reg [31:0] blinkCnt_ff;
	reg        blink_ff;
	reg        chargingPrev_ff;

	wire enFall   = enPrev_ff & ~sEnable;
	wire supplyOk = ~sUvlo & ~sOvIn & ~sSleep;
	wire allowed  = sEnable & supplyOk & ~sHot & ~sTsOut;
	wire charging = (state_ff == ST_CHARGE) & allowed;
	wire timerRun = charging & ~sCellOv;
	wire [31:0] safetyLimit = `CPS_SAFETY_SEC;
	wire safetyDone = ({17'h00000, safetySec_ff} == safetyLimit);

	// Battery detection windows
	wire detLoad = (state_ff != nxt_state);
	wire detLongExp;
	wire detShortExp;

	cps_timer #(.LIMIT(DET_LONG_CYC)) u_det_long (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.load     (detLoad | enFall),
		.run      (state_ff == ST_DETLOW),
		.expired  (detLongExp),
		.remain   ()
	);

	cps_timer #(.LIMIT(DET_SHORT_CYC)) u_det_short (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.load     (detLoad | enFall),
		.run      (state_ff == ST_DETRCH),
		.expired  (detShortExp),
		.remain   ()
	);

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF:
				if (sEnable & supplyOk)
					nxt_state = ST_DETLOW;
			ST_DETLOW:
				if (detLongExp)
					nxt_state = ST_CHARGE;
				else if (sBelowLow)
					nxt_state = ST_DETRCH;
			ST_DETRCH:
				if (sAboveRch)
					nxt_state = ST_DETLOW;              // Battery absent, restart
				else if (detShortExp)
					nxt_state = ST_CHARGE;
			ST_CHARGE:
				if (safetyDone)
					nxt_state = ST_FAULT;
				else if (ctrlFast_ff == 1'b0 && sAboveRch && currentStep == 4'h8)
					nxt_state = ST_DONE;
			ST_DONE:
				if (~sAboveRch)
					nxt_state = ST_DETLOW;
			ST_FAULT:
				if (~sAboveRch)
					nxt_state = ST_FAULT;
				else
					nxt_state = ST_FAULT;
			default:
				nxt_state = ST_OFF;
		endcase
		if (state_ff == ST_FAULT && chargingPrev_ff && ~sAboveRch)
			nxt_state = ST_DETLOW;
		if (~sEnable | sUvlo)
			nxt_state = ST_OFF;
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff        <= ST_OFF;
			enPrev_ff       <= 1'b0;
			chargingPrev_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			enPrev_ff <= sEnable;
			// Remembers that the battery was above recharge while in fault
			if (state_ff != ST_FAULT)
				chargingPrev_ff <= 1'b0;
			else if (sAboveRch)
				chargingPrev_ff <= 1'b1;
		end
	end

	// Safety timer in seconds; pauses rather than restarts
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			secCnt_ff    <= 32'h0000_0000;
			safetySec_ff <= 15'h0000;
		end else if (enFall || state_ff == ST_OFF || state_ff == ST_DETLOW) begin
			secCnt_ff    <= 32'h0000_0000;
			safetySec_ff <= 15'h0000;
		end else if (timerRun && !safetyDone) begin
			if (secCnt_ff == SEC_CYC - 32'h0000_0001) begin
				secCnt_ff    <= 32'h0000_0000;
				safetySec_ff <= safetySec_ff + 15'h0001;
			end else begin
				secCnt_ff <= secCnt_ff + 32'h0000_0001;
			end
		end
	end

	// Soft-start ramp, restarted on each entry to active charge
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stepCnt_ff  <= 32'h0000_0000;
			currentStep <= 4'h0;
		end else if (!charging) begin
			stepCnt_ff  <= 32'h0000_0000;
			currentStep <= 4'h0;
		end else if (currentStep != 4'h8) begin
			if (stepCnt_ff == STEP_CYC - 32'h0000_0001) begin
				stepCnt_ff  <= 32'h0000_0000;
				currentStep <= currentStep + 4'h1;
			end else begin
				stepCnt_ff <= stepCnt_ff + 32'h0000_0001;
			end
		end
	end

	// Low-side gating: the under-current latch clears only at the next cycle start
	wire syncAllowed = ~sAvgLow & ~sUnder5 & ~underLatch_ff;
	wire [31:0] refreshFull = `CPS_REFRESH_CYC;
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			underLatch_ff <= 1'b0;
			refresh_ff    <= 4'h0;
			highSideOn    <= 1'b0;
			lowSideOn     <= 1'b0;
		end else begin
			// A drop seen on the cycle-start edge still wins over the clear
			if (sUnder5)
				underLatch_ff <= 1'b1;
			else if (pwmCycleStart)
				underLatch_ff <= 1'b0;
			if (!charging || pwmCycleStart)
				refresh_ff <= 4'h0;
			else if (refresh_ff != 4'h0)
				refresh_ff <= refresh_ff - 4'h1;
			else if (~syncAllowed && sBoot && ~pwmHighReq && !lowSideOn)
				refresh_ff <= refreshFull[3:0];
			// Both switches off whenever charging is not allowed
			highSideOn <= charging & pwmHighReq & ~sCellOv & ~sOc;
			lowSideOn  <= charging & ~pwmHighReq &
				(syncAllowed | (refresh_ff != 4'h0));
		end
	end

	// Blink prescaler for the status pin
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			blinkCnt_ff <= 32'h0000_0000;
			blink_ff    <= 1'b0;
		end else if (blinkCnt_ff == BLINK_CYC - 32'h0000_0001) begin
			blinkCnt_ff <= 32'h0000_0000;
			blink_ff    <= ~blink_ff;
		end else begin
			blinkCnt_ff <= blinkCnt_ff + 32'h0000_0001;
		end
	end

	wire suspendCond = (state_ff == ST_CHARGE) & sEnable & supplyOk & (sHot | sTsOut);
	wire absentCond  = (state_ff == ST_DETRCH) & sAboveRch;
	wire blinkCond   = suspendCond | (state_ff == ST_FAULT) | (sOvIn & ~sUvlo) | absentCond;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			systemFromBattery   <= 1'b0;
			dischargeSinkOn     <= 1'b0;
			faultProbeCurrentOn <= 1'b0;
			precharge125mA      <= 1'b0;
			currentDivBy8       <= 1'b0;
			supplyValidOe       <= 1'b0;
			statusOe            <= 1'b0;
		end else begin
			systemFromBattery   <= sOvIn | sSleep;
			dischargeSinkOn     <= charging;
			faultProbeCurrentOn <= (state_ff == ST_FAULT) & ~sAboveRch
				& ~chargingPrev_ff & ~sUvlo;
			precharge125mA      <= (state_ff == ST_DETRCH) & allowed;
			currentDivBy8       <= charging & sTsMild;
			supplyValidOe       <= supplyOk;
			if (sUvlo || sSleep)
				statusOe <= 1'b0;
			else if (blinkCond)
				statusOe <= blink_ff;
			else
				statusOe <= charging;
		end
	end

	// APB slave: zero wait states, unmapped addresses error
	wire [31:0] statusWord = {16'h0000, 4'h0, currentStep, syncAllowed, currentDivBy8, sHot,
		supplyValidOe, absentCond, suspendCond, (state_ff == ST_FAULT), charging};
	wire apbAccess = psel & penable;
	wire hitCtrl   = (paddr == `CPS_CTRL_OFS);
	wire hitStat   = (paddr == `CPS_STAT_OFS);
	wire hitTimer  = (paddr == `CPS_TIMER_OFS);

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrlFast_ff <= 1'b0;
			prdata      <= 32'h0000_0000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~(hitCtrl | hitStat | hitTimer);
			if (apbAccess && pready && pwrite && hitCtrl)
				ctrlFast_ff <= pwdata[`CPS_CTRL_ENFAST];
			if (psel && !penable && !pwrite) begin
				if (hitCtrl)
					prdata <= {31'h00000000, ctrlFast_ff};
				else if (hitStat)
					prdata <= statusWord;
				else if (hitTimer)
					prdata <= {17'h00000, safetySec_ff};
				else
					prdata <= 32'h0000_0000;
			end
		end
	end
endmodule

// File: logic/cps_regs.vh
// Constants for the charger protection and status control block.
// Assumes a 125 MHz core clock; the safety limit counts seconds, the other counts are in core_clk cycles.
`ifndef CPS_REGS_VH
`define CPS_REGS_VH
// APB register byte offsets
`define CPS_CTRL_OFS       12'h000
`define CPS_STAT_OFS       12'h004
`define CPS_TIMER_OFS      12'h008
// Control field positions
`define CPS_CTRL_ENFAST    0
`define CPS_CTRL_RESET     32'h0000_0000
// Status field positions
`define CPS_ST_CHARGING    0
`define CPS_ST_TMRFAULT    1
`define CPS_ST_SUSPEND     2
`define CPS_ST_BATABSENT   3
`define CPS_ST_SUPPLYOK    4
`define CPS_ST_DIEHOT      5
`define CPS_ST_REDUCED     6
`define CPS_ST_SYNC        7
`define CPS_ST_STEP_LO     8
// Timing, written as printed and converted at 125 MHz (8 ns period)
`define CPS_CLK_NS         8
`define CPS_REFRESH_NS     80
`define CPS_REFRESH_CYC    (`CPS_REFRESH_NS / `CPS_CLK_NS)
`define CPS_STEP_US        1600
`define CPS_STEP_CYC       (`CPS_STEP_US * 1000 / `CPS_CLK_NS)
`define CPS_DET_SHORT_MS   500
`define CPS_DET_SHORT_CYC  (`CPS_DET_SHORT_MS * 125000)
`define CPS_DET_LONG_MS    1000
`define CPS_DET_LONG_CYC   (`CPS_DET_LONG_MS * 125000)
`define CPS_BLINK_MS       1000
`define CPS_BLINK_CYC      (`CPS_BLINK_MS * 125000)
`define CPS_SAFETY_HR      5
`define CPS_SAFETY_SEC     (`CPS_SAFETY_HR * 3600)
`define CPS_SEC_CYC        125000000
`endif

// File: logic/cps_sync2.v
// Two-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to core_clk.
`timescale 1ns/1ps
module cps_sync2 (
	// Clock and reset
	input  wire core_clk,
	input  wire reset_n,
	// Level in and out
	input  wire asyncIn,
	output reg  syncOut
);
	reg stageOne_ff;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stageOne_ff <= 1'b0;
			syncOut     <= 1'b0;
		end else begin
			stageOne_ff <= asyncIn;
			syncOut     <= stageOne_ff;
		end
	end
endmodule

// File: logic/cps_timer.v
// Down-counter with load, pause and expiry pulse; used for the battery detection windows.
// Assumes load and run come from core_clk logic.
`timescale 1ns/1ps
module cps_timer #(
	parameter [31:0] LIMIT = 32'h0000_0010
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        reset_n,
	// Control
	input  wire        load,
	input  wire        run,
	// Result
	output reg         expired,
	output wire [31:0] remain
);
	reg [31:0] count_ff;

	assign remain = count_ff;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_ff <= 32'h0000_0000;
			expired  <= 1'b0;
		end else if (load) begin
			count_ff <= LIMIT;
			expired  <= 1'b0;
		end else if (run && count_ff != 32'h0000_0000) begin
			count_ff <= count_ff - 32'h0000_0001;
			expired  <= (count_ff == 32'h0000_0001);
		end else begin
			expired  <= 1'b0;
		end
	end
endmodule

// File: tb/cps_checker.sv
// Property checker for the charger supervision block, bound into cps_top.
// Assumes each flag passes two sync stages, so a 5-cycle hold settles outputs.
`timescale 1ns/1ps
module cps_checker (
	// Clock and reset
	input wire core_clk,
	input wire reset_n,
	// Flags
	input wire senseAvgUnder1p25mv,
	input wire inputOvervoltage,
	input wire supplyUndervoltageLockout,
	input wire cellOvervoltageProtect,
	input wire dieOvertempShutdown,
	input wire thermistorOutsideLimits,
	input wire overcurrent160,
	input wire sleepCondition,
	input wire cellAboveRecharge,
	// Commands
	input wire highSideOn,
	input wire lowSideOn,
	input wire systemFromBattery,
	input wire dischargeSinkOn,
	input wire faultProbeCurrentOn,
	input wire supplyValidOe
);
	reg [7:0] avgRun_ff;
	reg [7:0] lowRun_ff;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Saturating run lengths; a long non-sync stretch bounds any low-side pulse
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			avgRun_ff <= 8'h00;
			lowRun_ff <= 8'h00;
		end else begin
			avgRun_ff <= !senseAvgUnder1p25mv ? 8'h00 : avgRun_ff + {7'h00, avgRun_ff != 8'hFF};
			lowRun_ff <= !lowSideOn ? 8'h00 : lowRun_ff + {7'h00, lowRun_ff != 8'hFF};
		end
	end
	a_lockout_off: assert property (
		supplyUndervoltageLockout [*5] |-> !highSideOn && !lowSideOn && !dischargeSinkOn)
		else $error("lockout left a switch or sink on");
	a_cellov_nohigh: assert property (
		cellOvervoltageProtect [*5] |-> !highSideOn) else $error("high side on in overvoltage");
	a_overcur_nohigh: assert property (
		overcurrent160 [*5] |-> !highSideOn) else $error("high side on in overcurrent");
	a_input_ov_path: assert property (
		inputOvervoltage [*5] |-> systemFromBattery && !dischargeSinkOn)
		else $error("input overvoltage did not move supply path");
	a_temp_switches: assert property (
		(dieOvertempShutdown || thermistorOutsideLimits) [*5] |-> !highSideOn && !lowSideOn)
		else $error("switch on during temperature suspend");
	a_valid_on: assert property (
		(!supplyUndervoltageLockout && !inputOvervoltage && !sleepCondition) [*5]
		|-> supplyValidOe) else $error("supply valid pin off with good supply");
	a_valid_off: assert property (
		(supplyUndervoltageLockout || inputOvervoltage || sleepCondition) [*5]
		|-> !supplyValidOe) else $error("supply valid pin on with bad supply");
	a_probe_below: assert property (
		cellAboveRecharge [*5] |-> !faultProbeCurrentOn) else $error("probe on above recharge");
	a_refresh_width: assert property (
		avgRun_ff > 8'h14 && lowSideOn |-> lowRun_ff < 8'h0B)
		else $error("low side pulse too long in non-sync mode");
	c_high: cover property (highSideOn);
	c_probe: cover property (faultProbeCurrentOn);
	c_valid_drop: cover property ($fell(supplyValidOe));
endmodule
bind cps_top cps_checker u_chk (
	.core_clk(core_clk), .reset_n(reset_n), .senseAvgUnder1p25mv(senseAvgUnder1p25mv),
	.inputOvervoltage(inputOvervoltage), .supplyUndervoltageLockout(supplyUndervoltageLockout),
	.cellOvervoltageProtect(cellOvervoltageProtect), .dieOvertempShutdown(dieOvertempShutdown),
	.thermistorOutsideLimits(thermistorOutsideLimits), .overcurrent160(overcurrent160),
	.sleepCondition(sleepCondition), .cellAboveRecharge(cellAboveRecharge),
	.highSideOn(highSideOn), .lowSideOn(lowSideOn), .systemFromBattery(systemFromBattery),
	.dischargeSinkOn(dischargeSinkOn), .faultProbeCurrentOn(faultProbeCurrentOn),
	.supplyValidOe(supplyValidOe)
);

// File: tb/cps_partner.sv
// Power stage and status host model: modulator, sense flags, pulled-up pins.
// Assumes the block's clock; cycle start comes every 16 cycles.
`timescale 1ns/1ps
module cps_partner (
	// Clock and reset
	input  wire  core_clk,
	input  wire  reset_n,
	// Open-drain enables from the block
	input  wire  supplyValidOe,
	input  wire  statusOe,
	// Power stage flags and modulator
	output logic senseUnder5mv,
	output logic senseAvgUnder1p25mv,
	output logic bootstrapLow,
	output logic pwmCycleStart,
	output logic pwmHighReq,
	// Pin levels seen by the host
	output wire  supplyValidN,
	output wire  statusN
);
	integer      seed = 32'hFB5C90AF;
	logic [31:0] rnd;
	logic [5:0]  phase;
	// External pull-ups: a released pin reads high
	assign supplyValidN = supplyValidOe ? 1'b0 : 1'b1;
	assign statusN      = statusOe ? 1'b0 : 1'b1;
	always @(posedge core_clk) begin
		rnd = $random(seed);
		if (!reset_n) begin
			{senseUnder5mv, senseAvgUnder1p25mv, bootstrapLow, pwmCycleStart} <= 4'h0;
			pwmHighReq <= 1'b0;
			phase <= 6'h00;
		end else begin
			phase <= phase + 6'h01;
			pwmCycleStart <= (phase[3:0] == 4'hF);
			pwmHighReq <= rnd[0];
			senseUnder5mv <= rnd[1];
			bootstrapLow <= rnd[2] & rnd[3];
			// Averaged flag moves slowly, as a filtered level would
			if (phase == 6'h3F)
				senseAvgUnder1p25mv <= rnd[4];
		end
	end
endmodule

// File: tb/cps_top_tb.sv
// Self-checking bench for cps_top: APB reads and writes note expectations in a queue.
// Assumes shortened counts; the partner model plays the power stage.
`timescale 1ns/1ps
`include "cps_regs.vh"
module cps_top_tb;
	logic        core_clk, reset_n, psel, penable, pwrite, chgEn, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv, t1;
	logic [9:0]  flg;
	logic [32:0] qe, qm;
	logic [65:0] q[$];
	logic        hiOn, loOn, sysBat, sinkOn, probeOn, pre125, div8, svOe, stOe;
	logic [3:0]  step;
	wire         senseU, senseA, bootL, cycS, hiReq, svN, stN, last;
	int          err_total, cmp_count, tick, tg;
	int          pz[3] = '{2, 3, 4};
	int          sz[3] = '{0, 1, 7};
	cps_top #(.STEP_CYC(32'h8), .DET_SHORT_CYC(32'h14), .DET_LONG_CYC(32'h28),
		.BLINK_CYC(32'h4), .SEC_CYC(32'h2)) u_cps_top (
		.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .senseUnder5mv(senseU), .senseAvgUnder1p25mv(senseA),
		.bootstrapLow(bootL), .inputOvervoltage(flg[0]), .supplyUndervoltageLockout(flg[1]),
		.cellOvervoltageProtect(flg[2]), .dieOvertempShutdown(flg[3]),
		.thermistorOutsideLimits(flg[4]), .thermistorMildBand(flg[5]),
		.overcurrent160(flg[6]), .sleepCondition(flg[7]), .cellAboveRecharge(flg[8]),
		.cellBelowLowThreshold(flg[9]), .chargeEnable(chgEn), .pwmCycleStart(cycS),
		.pwmHighReq(hiReq), .highSideOn(hiOn), .lowSideOn(loOn), .systemFromBattery(sysBat),
		.dischargeSinkOn(sinkOn), .faultProbeCurrentOn(probeOn), .precharge125mA(pre125),
		.currentStep(step), .currentDivBy8(div8), .supplyValidOe(svOe), .statusOe(stOe));
	cps_partner u_cps_partner (.core_clk(core_clk), .reset_n(reset_n), .supplyValidOe(svOe),
		.statusOe(stOe), .senseUnder5mv(senseU), .senseAvgUnder1p25mv(senseA),
		.bootstrapLow(bootL), .pwmCycleStart(cycS), .pwmHighReq(hiReq),
		.supplyValidN(svN), .statusN(stN));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic check(input logic [32:0] s, input logic [32:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("ERROR t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task report_and_stop;
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		q.push_back({e, m});
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rdv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
		apb(1'b0, a, 32'h0, e, m);
	endtask
	// Compares every completed transfer against the oldest noted expectation
	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1) begin
			{qe, qm} = q.pop_front();
			check({pslverr, prdata} & qm, qe & qm);
		end
	end
	always @(posedge core_clk) begin
		tick++;
		if (tick > 50000) begin
			err_total++;
			report_and_stop;
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, flg, chgEn} = 0;
		reset_n = 1'b0;
		cyc(12);
		reset_n <= 1'b1;
		rd(`CPS_CTRL_OFS, 33'h0, 33'h1_FFFF_FFFF);
		rd(12'h00C, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
		apb(1'b1, 12'h00C, 32'hFFFF_FFFF, 33'h1_0000_0000, 33'h1_0000_0000);
		apb(1'b1, `CPS_TIMER_OFS, 32'hFFFF_FFFF, 33'h0, 33'h1_0000_0000);
		rd(`CPS_TIMER_OFS, 33'h0, 33'h0_FFFF_FFFF);
		apb(1'b1, `CPS_CTRL_OFS, 32'h1, 33'h0, 33'h1_0000_0000);
		rd(`CPS_CTRL_OFS, 33'h1, 33'h1_FFFF_FFFF);
		chgEn <= 1'b1;
		cyc(150);
		rd(`CPS_STAT_OFS, 33'h811, 33'hF13);
		check({32'h0, stOe}, 33'h1);
		check({32'h0, sinkOn}, 33'h1);
		check({29'h0, step}, 33'h8);
		flg[6] <= 1'b1;
		flg[5] <= 1'b1;
		cyc(20);
		check({32'h0, div8}, 33'h1);
		flg[6] <= 1'b0;
		flg[5] <= 1'b0;
		cyc(20);
		check({32'h0, div8}, 33'h0);
		foreach (pz[i]) begin
			flg[pz[i]] <= 1'b1;
			cyc(10);
			rd(`CPS_TIMER_OFS, 33'h0, 33'h1_0000_0000);
			t1 = rdv;
			cyc(40);
			rd(`CPS_TIMER_OFS, {1'b0, t1}, 33'h0_FFFF_FFFF);
			flg[pz[i]] <= 1'b0;
			cyc(20);
			rd(`CPS_TIMER_OFS, 33'h0, 33'h1_0000_0000);
			check({32'h0, rdv > t1 && rdv < t1 + 32'h10}, 33'h1);
			cyc(100);
		end
		chgEn <= 1'b0;
		cyc(10);
		rd(`CPS_TIMER_OFS, 33'h0, 33'h0_FFFF_FFFF);
		chgEn <= 1'b1;
		cyc(36300);
		rd(`CPS_STAT_OFS, 33'h2, 33'h3);
		check({32'h0, sinkOn}, 33'h0);
		check({32'h0, probeOn}, 33'h1);
		tg = 0;
		for (int k = 0; k < 40; k++) begin
			@(posedge core_clk);
			tg += (stN !== last);
		end
		check({32'h0, tg >= 9 && tg <= 11}, 33'h1);
		flg[8] <= 1'b1;
		cyc(10);
		check({32'h0, probeOn}, 33'h0);
		rd(`CPS_STAT_OFS, 33'h2, 33'h2);
		flg[8] <= 1'b0;
		cyc(10);
		rd(`CPS_STAT_OFS, 33'h0, 33'h2);
		foreach (sz[i]) begin
			flg[sz[i]] <= 1'b1;
			cyc(10);
			check({32'h0, svN}, 33'h1);
			rd(`CPS_STAT_OFS, 33'h0, 33'h11);
			flg[sz[i]] <= 1'b0;
			cyc(10);
			check({32'h0, svN}, 33'h0);
		end
		// Low-cell path: detection moves to precharge, short window then charges
		chgEn <= 1'b0;
		flg[9] <= 1'b1;
		cyc(10);
		chgEn <= 1'b1;
		cyc(20);
		check({32'h0, pre125}, 33'h1);
		flg[9] <= 1'b0;
		cyc(20);
		check({32'h0, pre125}, 33'h0);
		rd(`CPS_STAT_OFS, 33'h1, 33'h1);
		report_and_stop;
	end
	// Previous status pin level, one cycle behind, for toggle counting
	logic stPrev;
	always @(posedge core_clk) stPrev <= stN;
	assign last = stPrev;
endmodule
